// ### logic/pcseq_top.sv
/*
  program counter sequencer: next fetch address, table lookup into the
  data buffer, calls, returns, interrupt vectors.
  assumes a decoder supplies a one-cycle op strobe with operand, and a
  synchronous program memory returning the word one cycle after address.
*/
`timescale 1ns/1ps
`default_nettype none

`include "pcseq_params.svh"

// What this block does
// - instruction store holds 4,096 words of sixteen bits.
// - fetch addresses span 0000H through 0FFFH only.
// - each fetch returns one full sixteen-bit instruction.
// - fetch address counter is 12 bits; bit 11 is the page.
// - direct jump takes page from opcode, low bits from operand.
// - indirect jump loads all twelve bits from the pointer register.
// - direct call forces bit 11 low, operand supplies lower bits.
// - indirect call loads full target from the pointer register.
// - table lookup reads word at pointer into the data buffer.
// - all three returns reload counter from selected stack entry.
// - accepted interrupt loads the source's fixed vector.
// - power-on or chip-enable reset clears the counter to zero.
// - vectors: pin 0004H, timer12 0003H, btimer1 0002H, serial 0001H.
// - call, lookup, interrupt pre-decrement pointer, then store return.
// - stack holds five twelve-bit entries, sixth has no storage.
module pcseq_top
  import pcseq_pkg::*;
(
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_ce_rst,
  input  wire logic                    i_op_valid,
  input  wire logic [3:0]              i_op,
  input  wire logic                    i_jump_page,
  input  wire logic [10:0]             i_operand,
  input  wire pcseq_addr_type          i_address_pointer_register,
  input  wire logic [`PCSEQ_IRQ_N-1:0] i_irq_req,
  input  wire logic                    i_irq_enable,
  input  wire pcseq_word_type          i_mem_rdata,
  output pcseq_addr_type               o_fetch_address_counter,
  output pcseq_addr_type               o_mem_addr,
  output logic [`PCSEQ_IRQ_N-1:0]      o_irq_ack,
  output pcseq_word_type               o_data_buffer,
  output logic                         o_data_buffer_valid,
  output logic                         o_skip_next,
  output logic [`PCSEQ_SP_W-1:0]       o_stack_pointer,
  output logic                         o_busy
);

  pcseq_state_type state_q;
  pcseq_state_type state_d;
  pcseq_addr_type  pc_q;
  pcseq_addr_type  pc_d;
  pcseq_addr_type  mem_addr_q;
  pcseq_addr_type  stack_top;
  pcseq_addr_type  irq_vector;
  pcseq_addr_type  pc_inc;
  pcseq_addr_type  push_addr;
  pcseq_addr_type  jump_target;
  pcseq_addr_type  call_target;
  pcseq_word_type  data_buffer_q;
  logic            data_buffer_valid_q;
  logic            skip_q;
  logic [`PCSEQ_IRQ_N-1:0] irq_grant;
  logic [`PCSEQ_IRQ_N-1:0] irq_ack_q;
  logic            irq_any;
  logic            irq_take;
  logic            push;
  logic            pop;
  pcseq_op_type    op;

  // codes 9 to F fall to the sequential default
  assign op = pcseq_op_type'(i_op);

  assign pc_inc = pc_q + 12'h001;

  assign jump_target = {i_jump_page, i_operand};
  // direct call lands in page 0
  assign call_target = {1'b0, i_operand};

  // fixed priority picks one source per take
  pcseq_irq_arb u_irq_arb (
    .i_req    (i_irq_req),
    .o_any    (irq_any),
    .o_grant  (irq_grant),
    .o_vector (irq_vector)
  );

  // interrupts are only taken between instructions in the run state
  assign irq_take = irq_any && i_irq_enable &&
                    (state_q == PCSEQ_ST_RUN) && !i_op_valid;

  always_comb begin
    push      = 1'b0;
    push_addr = pc_inc;
    if (irq_take) begin
      push      = 1'b1;
      // the word at pc_q was fetched but has not run: it is the return
      push_addr = pc_q;
    end else if (state_q == PCSEQ_ST_RUN && i_op_valid) begin
      case (op)
        PCSEQ_OP_CALL,
        PCSEQ_OP_CALL_IND,
        PCSEQ_OP_TABLE_LOOKUP: begin
          push = 1'b1;
        end
        default: begin
          push = 1'b0;
        end
      endcase
    end
  end

  // pop on returns and at the end of a table lookup
  always_comb begin
    pop = 1'b0;
    if (state_q == PCSEQ_ST_TABLE) begin
      pop = 1'b1;
    end else if (state_q == PCSEQ_ST_RUN && i_op_valid && !irq_take) begin
      case (op)
        PCSEQ_OP_RETURN,
        PCSEQ_OP_RETURN_SKIP,
        PCSEQ_OP_IRQ_RETURN: begin
          pop = 1'b1;
        end
        default: begin
          pop = 1'b0;
        end
      endcase
    end
  end

  // nesting past five is not guarded: the program must avoid it
  pcseq_stack #(
    .DEPTH (`PCSEQ_STACK_DEPTH)
  ) u_stack (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_soft_rst  (i_ce_rst),
    .i_push      (push),
    .i_pop       (pop),
    .i_push_addr (push_addr),
    .o_top       (stack_top),
    .o_sp        (o_stack_pointer)
  );

  // next counter value and state
  always_comb begin
    pc_d    = pc_q;
    state_d = state_q;
    case (state_q)
      PCSEQ_ST_RUN: begin
        if (irq_take) begin
          pc_d = irq_vector;
        end else if (i_op_valid) begin
          case (op)
            PCSEQ_OP_JUMP: begin
              pc_d = jump_target;
            end
            PCSEQ_OP_JUMP_IND,
            PCSEQ_OP_CALL_IND: begin
              pc_d = i_address_pointer_register;
            end
            PCSEQ_OP_CALL: begin
              pc_d = call_target;
            end
            PCSEQ_OP_TABLE_LOOKUP: begin
              pc_d    = i_address_pointer_register;
              state_d = PCSEQ_ST_TABLE;
            end
            PCSEQ_OP_RETURN,
            PCSEQ_OP_IRQ_RETURN: begin
              pc_d = stack_top;
            end
            PCSEQ_OP_RETURN_SKIP: begin
              pc_d    = stack_top;
              state_d = PCSEQ_ST_SKIP;
            end
            default: begin
              pc_d = pc_inc;
            end
          endcase
        end
      end
      PCSEQ_ST_TABLE: begin
        // lookup done: resume at the saved return address
        pc_d    = stack_top;
        state_d = PCSEQ_ST_RUN;
      end
      PCSEQ_ST_SKIP: begin
        // the returned-to instruction is skipped
        pc_d    = pc_inc;
        state_d = PCSEQ_ST_RUN;
      end
      default: begin
        // an illegal state code recovers to run from address zero
        pc_d    = `PCSEQ_PC_RESET;
        state_d = PCSEQ_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pc_q <= `PCSEQ_PC_RESET;
    end else if (i_ce_rst) begin
      pc_q <= `PCSEQ_PC_RESET;
    end else begin
      pc_q <= pc_d;
    end
  end

  // chip-enable reset also abandons a table or skip in flight
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= PCSEQ_ST_RUN;
    end else if (i_ce_rst) begin
      state_q <= PCSEQ_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // one word per fetch
  // registered from pc_d so the address moves together with pc_q
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mem_addr_q <= `PCSEQ_PC_RESET;
    end else if (i_ce_rst) begin
      mem_addr_q <= `PCSEQ_PC_RESET;
    end else begin
      mem_addr_q <= pc_d;
    end
  end

  // capture into data buffer
  // chip-enable reset leaves the buffer contents alone
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      data_buffer_q <= 16'h0000;
    end else if (state_q == PCSEQ_ST_TABLE && !i_ce_rst) begin
      data_buffer_q <= i_mem_rdata;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      data_buffer_valid_q <= 1'b0;
    end else begin
      data_buffer_valid_q <= (state_q == PCSEQ_ST_TABLE) && !i_ce_rst;
    end
  end

  // one-cycle echo of the grant so the source can drop its request
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_ack_q <= 4'h0;
    end else if (irq_take && !i_ce_rst) begin
      irq_ack_q <= irq_grant;
    end else begin
      irq_ack_q <= 4'h0;
    end
  end

  // the decoder voids the word after a skipping return on this pulse
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= (state_q == PCSEQ_ST_SKIP) && !i_ce_rst;
    end
  end

  assign o_fetch_address_counter = pc_q;
  assign o_mem_addr              = mem_addr_q;
  assign o_irq_ack               = irq_ack_q;
  assign o_data_buffer           = data_buffer_q;
  assign o_data_buffer_valid     = data_buffer_valid_q;
  assign o_skip_next             = skip_q;
  // decoder must hold off while the sequencer owns the fetch slot
  assign o_busy                  = (state_q != PCSEQ_ST_RUN);

endmodule : pcseq_top

`default_nettype wire

// ### logic/pcseq_params.svh
/*
  timing-free constants for the program counter sequencer: widths,
  vector addresses, reset values, stack geometry.
  assumes inclusion by bare name from logic/.
*/
`ifndef PCSEQ_PARAMS_SVH
`define PCSEQ_PARAMS_SVH

`define PCSEQ_ADDR_W        12
`define PCSEQ_WORD_W        16
`define PCSEQ_PAGE_BIT      11
`define PCSEQ_ADDR_MAX      12'hFFF
`define PCSEQ_CALL_MAX      12'h7FF
`define PCSEQ_PC_RESET      12'h000
`define PCSEQ_VEC_EXT       12'h004
`define PCSEQ_VEC_TMR12     12'h003
`define PCSEQ_VEC_BTM1      12'h002
`define PCSEQ_VEC_SER       12'h001
`define PCSEQ_STACK_DEPTH   5
`define PCSEQ_SP_W          4
`define PCSEQ_SP_RESET      4'h5
`define PCSEQ_IRQ_N         4

`endif

// ### logic/pcseq_pkg.sv
/*
  types shared by the sequencer and its helpers.
  assumes pcseq_params.svh sits beside it.
*/
`include "pcseq_params.svh"

package pcseq_pkg;

  typedef logic [`PCSEQ_ADDR_W-1:0] pcseq_addr_type;
  typedef logic [`PCSEQ_WORD_W-1:0] pcseq_word_type;

  // flow operation decoded by the instruction decoder
  typedef enum logic [3:0] {
    PCSEQ_OP_SEQ          = 4'h0,
    PCSEQ_OP_JUMP         = 4'h1,
    PCSEQ_OP_JUMP_IND     = 4'h2,
    PCSEQ_OP_CALL         = 4'h3,
    PCSEQ_OP_CALL_IND     = 4'h4,
    PCSEQ_OP_TABLE_LOOKUP = 4'h5,
    PCSEQ_OP_RETURN       = 4'h6,
    PCSEQ_OP_RETURN_SKIP  = 4'h7,
    PCSEQ_OP_IRQ_RETURN   = 4'h8
  } pcseq_op_type;

  // one-hot sequencer states
  typedef enum logic [2:0] {
    PCSEQ_ST_RUN   = 3'h1,
    PCSEQ_ST_TABLE = 3'h2,
    PCSEQ_ST_SKIP  = 3'h4
  } pcseq_state_type;

endpackage : pcseq_pkg

// ### logic/pcseq_irq_arb.sv
/*
  fixed priority interrupt arbiter producing the vector address.
  assumes request lines are already synchronous to i_sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

`include "pcseq_params.svh"

module pcseq_irq_arb
  import pcseq_pkg::*;
(
  input  wire logic [`PCSEQ_IRQ_N-1:0] i_req,
  output logic                         o_any,
  output logic [`PCSEQ_IRQ_N-1:0]      o_grant,
  output pcseq_addr_type               o_vector
);

  always_comb begin
    o_grant  = 4'h0;
    o_vector = `PCSEQ_PC_RESET;
    if (i_req[3]) begin
      o_grant  = 4'h8;
      o_vector = `PCSEQ_VEC_EXT;
    end else if (i_req[2]) begin
      o_grant  = 4'h4;
      o_vector = `PCSEQ_VEC_TMR12;
    end else if (i_req[1]) begin
      o_grant  = 4'h2;
      o_vector = `PCSEQ_VEC_BTM1;
    end else if (i_req[0]) begin
      o_grant  = 4'h1;
      o_vector = `PCSEQ_VEC_SER;
    end
  end

  assign o_any = |i_req;

endmodule : pcseq_irq_arb

`default_nettype wire

// ### logic/pcseq_stack.sv
/*
  return address stack: five 12-bit entries, pointer starts at 5.
  assumes at most one of push or pop per cycle.
*/
`timescale 1ns/1ps
`default_nettype none

`include "pcseq_params.svh"

module pcseq_stack
  import pcseq_pkg::*;
#(
  parameter int DEPTH = `PCSEQ_STACK_DEPTH
) (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_soft_rst,
  input  wire logic                    i_push,
  input  wire logic                    i_pop,
  input  wire pcseq_addr_type          i_push_addr,
  output pcseq_addr_type               o_top,
  output logic [`PCSEQ_SP_W-1:0]       o_sp
);

  localparam int SP_W = `PCSEQ_SP_W;

  logic [`PCSEQ_SP_W-1:0] sp_q;
  logic [`PCSEQ_SP_W-1:0] sp_dec;
  pcseq_addr_type         entry_q [DEPTH];

  assign sp_dec = sp_q - 4'h1;
  assign o_sp   = sp_q;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sp_q <= `PCSEQ_SP_RESET;
    end else if (i_soft_rst) begin
      sp_q <= `PCSEQ_SP_RESET;
    end else if (i_push) begin
      sp_q <= sp_dec;
    end else if (i_pop) begin
      sp_q <= sp_q + 4'h1;
    end
  end

  for (genvar g = 0; g < DEPTH; g++) begin : g_entry
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
        entry_q[g] <= `PCSEQ_PC_RESET;
      end else if (i_push && sp_dec == SP_W'(g)) begin
        entry_q[g] <= i_push_addr;
      end
    end
  end

  // the missing sixth position reads as zero
  always_comb begin
    o_top = `PCSEQ_PC_RESET;
    for (int k = 0; k < DEPTH; k++) begin
      if (sp_q == k[`PCSEQ_SP_W-1:0]) begin
        o_top = entry_q[k];
      end
    end
  end

endmodule : pcseq_stack

`default_nettype wire

// ### tb/pcseq_asserts.sv
/*
  concurrent checks on the sequencer top ports.
  assumes it is bound onto pcseq_top.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcseq_params.svh"
module pcseq_asserts
  import pcseq_pkg::*;
(
  input wire logic           i_sys_clk,
  input wire logic           i_rst,
  input wire logic           i_ce_rst,
  input wire logic           i_op_valid,
  input wire logic [3:0]     i_op,
  input wire logic           i_jump_page,
  input wire logic [10:0]    i_operand,
  input wire pcseq_addr_type i_address_pointer_register,
  input wire logic [3:0]     i_irq_req,
  input wire logic           i_irq_enable,
  input wire pcseq_word_type i_mem_rdata,
  input wire pcseq_addr_type o_fetch_address_counter,
  input wire logic [3:0]     o_irq_ack,
  input wire pcseq_word_type o_data_buffer,
  input wire logic           o_data_buffer_valid,
  input wire logic           o_skip_next,
  input wire logic [3:0]     o_stack_pointer,
  input wire logic           o_busy
);
  logic           run;
  logic           tk;
  logic           irq;
  pcseq_addr_type pc;
  pcseq_addr_type vec;
  assign pc = o_fetch_address_counter;
  // chip-enable reset overrides any request at the same edge
  assign run = !o_busy && !i_ce_rst;
  assign tk = run && i_op_valid && !(i_irq_enable && |i_irq_req);
  assign irq = run && !i_op_valid && i_irq_enable && |i_irq_req;
  assign vec = i_irq_req[3] ? 12'h004 : i_irq_req[2] ? 12'h003 :
               i_irq_req[1] ? 12'h002 : 12'h001;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_tbl;
    tk && i_op == 4'h5;
  endsequence
  sequence s_skp;
    tk && i_op == 4'h7;
  endsequence
  a_seq_step: assert property (
    tk && i_op == 4'h0 |=> pc == $past(pc) + 12'h001) else $error("step");
  a_jump_direct: assert property (
    tk && i_op == 4'h1 |=> pc == $past({i_jump_page, i_operand}))
    else $error("jump");
  a_indirect_load: assert property (
    tk && (i_op == 4'h2 || i_op == 4'h4)
    |=> pc == $past(i_address_pointer_register)) else $error("indirect");
  a_call_page0: assert property (
    tk && i_op == 4'h3 |=> pc == {1'b0, $past(i_operand)}
    && o_stack_pointer == $past(o_stack_pointer) - 4'h1) else $error("call");
  a_return_pop: assert property (
    tk && (i_op == 4'h6 || i_op == 4'h8)
    |=> o_stack_pointer == $past(o_stack_pointer) + 4'h1) else $error("ret");
  a_table_walk: assert property (
    s_tbl |=> (o_busy && pc == $past(i_address_pointer_register)) ##1
    (o_data_buffer_valid && o_data_buffer == $past(i_mem_rdata)
    && pc == $past(pc, 2) + 12'h001)) else $error("table");
  a_skip_walk: assert property (
    s_skp |=> o_busy ##1 (o_skip_next && pc == $past(pc) + 12'h001))
    else $error("skip");
  a_irq_vector: assert property (
    irq |=> pc == $past(vec) && o_irq_ack != 4'h0) else $error("vector");
  a_irq_push: assert property (
    irq |=> o_stack_pointer == $past(o_stack_pointer) - 4'h1)
    else $error("irq push");
  a_ce_clear: assert property (
    i_ce_rst |=> pc == 12'h000 && o_stack_pointer == 4'h5) else $error("ce");
endmodule : pcseq_asserts
bind pcseq_top pcseq_asserts u_chk (.i_sys_clk, .i_rst, .i_ce_rst,
  .i_op_valid, .i_op, .i_jump_page, .i_operand, .i_address_pointer_register,
  .i_irq_req, .i_irq_enable, .i_mem_rdata, .o_fetch_address_counter,
  .o_irq_ack, .o_data_buffer, .o_data_buffer_valid, .o_skip_next,
  .o_stack_pointer, .o_busy);
`default_nettype wire

// ### tb/pcseq_mem_model.sv
/*
  program memory model, read combinationally at the registered address.
  assumes the address comes from o_mem_addr.
*/
`timescale 1ns/1ps
`default_nettype none
module pcseq_mem_model
  import pcseq_pkg::*;
(
  input  wire pcseq_addr_type i_addr,
  output pcseq_word_type      o_rdata
);
  // one whole word per address
  // address-dependent data, so a wrong table address shows up
  assign o_rdata = {~i_addr[3:0], i_addr};
endmodule : pcseq_mem_model
`default_nettype wire

// ### tb/tb_top.sv
/*
  self-checking bench for the program counter sequencer.
  assumes memory model and checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pcseq_pkg::*;
;
  logic           clk = 1'b0;
  logic           rst = 1'b1;
  logic           ce = 1'b0;
  logic           opv = 1'b0;
  logic           pg = 1'b0;
  logic           en = 1'b0;
  logic [3:0]     op = 4'h0;
  logic [3:0]     irq = 4'h0;
  logic [10:0]    opd = 11'h000;
  pcseq_addr_type ar = 12'h000;
  pcseq_addr_type pc;
  pcseq_addr_type maddr;
  pcseq_word_type rd;
  pcseq_word_type db;
  logic [3:0]     ack;
  logic [3:0]     sp;
  logic           dbv;
  logic           skp;
  logic           busy;
  int             n_fail = 0;
  int             cmp_count = 0;
  int             cyc = 0;
  pcseq_top uut (.i_sys_clk(clk), .i_rst(rst), .i_ce_rst(ce),
    .i_op_valid(opv), .i_op(op), .i_jump_page(pg), .i_operand(opd),
    .i_address_pointer_register(ar), .i_irq_req(irq), .i_irq_enable(en),
    .i_mem_rdata(rd), .o_fetch_address_counter(pc), .o_mem_addr(maddr),
    .o_irq_ack(ack), .o_data_buffer(db), .o_data_buffer_valid(dbv),
    .o_skip_next(skp), .o_stack_pointer(sp), .o_busy(busy));
  pcseq_mem_model u_mem (.i_addr(maddr), .o_rdata(rd));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic wrap_up();
    $display("compares %0d fails %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // whole run needs about 65 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      $display("Error at %0t: timeout", $time);
      wrap_up();
    end
  end
  task automatic chk_a(input pcseq_addr_type g, e, input string m);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_a
  task automatic chk_w(input pcseq_word_type g, e, input string m);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_w
  // one-cycle op strobe, sampled just after the taking edge
  task automatic issue(input logic [3:0] c, input logic p,
                       input logic [10:0] o, input pcseq_addr_type a);
    @(posedge clk);
    opv <= 1'b1;
    op <= c;
    pg <= p;
    opd <= o;
    ar <= a;
    @(posedge clk);
    opv <= 1'b0;
    #1;
  endtask : issue
  task automatic t_seq();
    chk_a(pc, 12'h000, "reset pc");
    chk_a({8'h00, sp}, 12'h005, "reset sp");
    issue(4'h0, 1'b0, 11'h000, 12'h000);
    chk_a(pc, 12'h001, "step");
    issue(4'h1, 1'b1, 11'h7FF, 12'h000);
    chk_a(pc, 12'hFFF, "page1 jump");
    issue(4'h0, 1'b0, 11'h000, 12'h000);
    chk_a(pc, 12'h000, "wrap");
    issue(4'h1, 1'b0, 11'h2AA, 12'h000);
    chk_a(pc, 12'h2AA, "page0 jump");
    issue(4'h2, 1'b0, 11'h000, 12'hFED);
    chk_a(pc, 12'hFED, "ind jump");
    issue(4'hF, 1'b0, 11'h000, 12'h000);
    chk_a(pc, 12'hFEE, "unknown op");
    $display("t_seq done");
  endtask : t_seq
  task automatic t_flow();
    issue(4'h3, 1'b1, 11'h7FF, 12'h000);
    chk_a(pc, 12'h7FF, "call");
    chk_a({8'h00, sp}, 12'h004, "call sp");
    issue(4'h4, 1'b0, 11'h000, 12'hC33);
    chk_a(pc, 12'hC33, "ind call");
    issue(4'h6, 1'b0, 11'h000, 12'h000);
    chk_a(pc, 12'h800, "return");
    issue(4'h5, 1'b0, 11'h000, 12'h5A5);
    chk_a(pc, 12'h5A5, "table addr");
    chk_w({15'h0000, busy}, 16'h0001, "table busy");
    chk_a(maddr, 12'h5A5, "table fetch");
    @(posedge clk);
    #1;
    chk_w(db, 16'hA5A5, "table word");
    chk_w({15'h0000, dbv}, 16'h0001, "table valid");
    chk_a(pc, 12'h801, "table resume");
    issue(4'h7, 1'b0, 11'h000, 12'h000);
    chk_a(pc, 12'hFEF, "skip return");
    @(posedge clk);
    #1;
    chk_a(pc, 12'hFF0, "skip step");
    chk_w({15'h0000, skp}, 16'h0001, "skip pulse");
    chk_a({8'h00, sp}, 12'h005, "stack empty");
    $display("t_flow done");
  endtask : t_flow
  task automatic t_irq();
    pcseq_addr_type v[4] = '{12'h001, 12'h002, 12'h003, 12'h004};
    pcseq_addr_type ret;
    for (int k = 0; k < 4; k++) begin
      ret = pc;
      @(posedge clk);
      // all lower sources pending too, so priority is exercised
      irq <= (4'h2 << k) - 4'h1;
      en <= 1'b1;
      @(posedge clk);
      irq <= 4'h0;
      #1;
      chk_a(pc, v[k], "vector");
      chk_w({12'h000, ack}, 16'h0001 << k, "ack");
      chk_a({8'h00, sp}, 12'h004, "irq sp");
      issue(4'h8, 1'b0, 11'h000, 12'h000);
      chk_a(pc, ret, "irq return");
    end
    @(posedge clk);
    en <= 1'b0;
    irq <= 4'h8;
    repeat (3) @(posedge clk);
    irq <= 4'h0;
    #1;
    chk_a(pc, ret, "masked irq");
    chk_w({12'h000, ack}, 16'h0000, "masked ack");
    $display("t_irq done");
  endtask : t_irq
  task automatic t_ce();
    issue(4'h3, 1'b0, 11'h123, 12'h000);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    ce <= 1'b0;
    #1;
    chk_a(pc, 12'h000, "ce pc");
    chk_a({8'h00, sp}, 12'h005, "ce sp");
    chk_w(db, 16'hA5A5, "ce keeps buffer");
    issue(4'h3, 1'b0, 11'h456, 12'h000);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_a(pc, 12'h000, "rst pc");
    chk_a(maddr, 12'h000, "rst fetch");
    chk_a({8'h00, sp}, 12'h005, "rst sp");
    chk_w(db, 16'h0000, "rst buffer");
    $display("t_ce done");
  endtask : t_ce
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_seq();
    t_flow();
    t_irq();
    t_ce();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
